// file: logic/dsl_pmd_signaling.sv
// Tone and data signaling for the dual simplex medium dependent sublayer.
`timescale 1ns/1ps

module dsl_pmd_signaling #(
	parameter int unsigned TX_DEPTH = dsl_pkg::TX_PIPE_DEPTH
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire dsl_pkg::dsl_apb_req_s apbReq,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [3:0]            txLanes,
	input  wire logic                  txDataEnable,
	input  wire logic [2:0]            txControlState,
	output logic                       txLine,
	output logic                       txLineEnable,
	input  wire logic                  rxLine,
	input  wire logic                  rxDataEnable,
	output logic [2:0]                 rxControlState,
	output logic                       rxRecoveredClock
);
	import dsl_pkg::*;

	// The latency window only holds for a narrow range of depths.
	if (TX_DEPTH + 1 < TX_LAT_MIN_BT || TX_DEPTH + 1 > TX_LAT_MAX_BT) begin
		$error("TX_DEPTH outside the permitted latency window");
	end

	// Map a transmit control state to a tone index, NONE for off/reserved.
	function automatic logic [2:0] tcsTone(input logic [2:0] tcs);
		case (tcs)
			TCS_ONE:   tcsTone = TONE_ONE;
			TCS_TWO:   tcsTone = TONE_TWO;
			TCS_THREE: tcsTone = TONE_THR;
			TCS_FOUR:  tcsTone = TONE_FOUR;
			TCS_FIVE:  tcsTone = TONE_FIVE;
			default:   tcsTone = TONE_NONE;
		endcase
	endfunction

	// Classify a measured run length. In a steady tone the trailing run of
	// one half merges with the leading run of the next, so every inner run
	// is the sum of the two half run lengths.
	function automatic logic [2:0] runTone(input logic [5:0] len);
		case (len)
			6'(RUN_A[0] + RUN_B[0]): runTone = TONE_ONE;
			6'(RUN_A[1] + RUN_B[1]): runTone = TONE_TWO;
			6'(RUN_A[2] + RUN_B[2]): runTone = TONE_THR;
			6'(RUN_A[3] + RUN_B[3]): runTone = TONE_FOUR;
			6'(RUN_A[4] + RUN_B[4]): runTone = TONE_FIVE;
			default:                 runTone = TONE_NONE;
		endcase
	endfunction

	// Register and bus state.
	logic [31:0] ctrl_r;          // Software control; bit 0 forces off.
	logic [31:0] prdata_r;        // Registered read data.
	logic        pready_r;        // Registered ready, one wait state.
	logic        pslverr_r;       // Registered error for unmapped words.

	// Transmit state.
	dsl_tx_e     txState_r;       // Sequencer state.
	logic [2:0]  txTone_r;        // Tone being sent.
	logic        halfB_r;         // High while in a second half pattern.
	logic [5:0]  bitCnt_r;        // Bit position within the half.
	logic [1:0]  laneSel_r;       // Lane being serialised this bit.
	logic [TX_DEPTH-1:0] pipeBit_r;   // Data delay line.
	logic [TX_DEPTH-1:0] pipeVal_r;   // Enable carried with the data.
	logic        txLine_r;
	logic        txLineEnable_r;

	// Receive state.
	logic        rxPrev_r;        // Previous received bit.
	logic [5:0]  runLen_r;        // Length of the run in progress.
	logic [5:0]  lastRun_r;       // Last completed run, for software.
	logic [2:0]  candTone_r;      // Tone of the recent runs.
	logic [1:0]  candCnt_r;       // Consecutive runs agreeing on it.
	logic [2:0]  altCnt_r;        // Consecutive single-bit runs.
	logic        inData_r;        // Data on link has been reported.
	logic        clkActive_r;     // Recovered clock is being driven.
	logic [1:0]  clkDiv_r;        // Quarter-rate divider.
	logic [2:0]  rxCode_r;
	logic        rx_recovered_clock_r;

	// Combinational helpers.
	logic [5:0]  halfRun;
	logic        halfEnd;
	logic        toneBit;
	logic [2:0]  reqTone;
	logic        laneBit;
	logic        pipeBusy;
	logic        runDone;
	logic [2:0]  doneTone;
	logic        confirmNow;
	logic        preambleHit;
	logic        forceOff;

	assign forceOff = ctrl_r[CTRL_FORCE_OFF];
	assign reqTone  = tcsTone(txControlState);
	assign laneBit  = txLanes[laneSel_r];
	// The tail stage is left out, so the sequencer leaves data in the very
	// cycle the last packet bit is launched and no stale bit follows it.
	assign pipeBusy = txDataEnable | (|pipeVal_r[TX_DEPTH-2:0]);

	// Each half is a run of one level and an equal run of the other, so
	// every half on its own is balanced.
	always_comb begin
		halfRun = halfB_r ? RUN_B[txTone_r] : RUN_A[txTone_r];
		halfEnd = (txState_r == TX_TONE) &&
			(bitCnt_r == 6'((halfRun << 1) - 6'h1));
		// First halves lead with ones, second halves with zeros.
		toneBit = (bitCnt_r < halfRun) ? ~halfB_r : halfB_r;
	end

	// APB slave; one wait state so every answer comes from a flip-flop.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready_r  <= 1'b0;
			prdata_r  <= 32'h0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= apbReq.psel & apbReq.penable & ~pready_r;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
			if (apbReq.psel && apbReq.penable && !pready_r) begin
				case (apbReq.paddr)
					ADDR_CTRL:   prdata_r <= ctrl_r;
					ADDR_STATUS: prdata_r <= {16'h0, clkActive_r, inData_r,
						rxCode_r, txTone_r, halfB_r, 3'h0,
						txState_r, txLineEnable_r, txLine_r};
					ADDR_RUN:    prdata_r <= {26'h0, lastRun_r};
					// Unmapped words answer with an error and zero data.
					default:     pslverr_r <= 1'b1;
				endcase
			end
		end
	end

	// Control register write, taken at the completing edge only.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ctrl_r <= CTRL_RESET;
		end else if (apbReq.psel && apbReq.penable && pready_r &&
				apbReq.pwrite && apbReq.paddr == ADDR_CTRL) begin
			ctrl_r <= {31'h0, apbReq.pwdata[CTRL_FORCE_OFF]};
		end
	end

	// Lane multiplexer and data delay line; the enable travels with the
	// data so the tail tells exactly when the last packet bit goes out.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			laneSel_r <= 2'h0;
			pipeBit_r <= '0;
			pipeVal_r <= '0;
		end else begin
			laneSel_r <= laneSel_r + 2'h1;
			pipeBit_r <= {pipeBit_r[TX_DEPTH-2:0], laneBit};
			pipeVal_r <= {pipeVal_r[TX_DEPTH-2:0], txDataEnable};
		end
	end

	// Transmit sequencer: tones change only at the end of a half.
	// A tone-one half is 32 bits, so a request can wait longer than 20
	// bits in the worst case; of the shorter tones only tone five, at 20 bits a half, meets the bound.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			txState_r <= TX_OFF;
			txTone_r  <= TONE_ONE;
			halfB_r   <= 1'b0;
			bitCnt_r  <= 6'h0;
		end else begin
			case (txState_r)
				TX_OFF: begin
					bitCnt_r <= 6'h0;
					halfB_r  <= 1'b0;
					if (txDataEnable) begin
						txState_r <= TX_DATA;
					end else if (reqTone != TONE_NONE && !forceOff) begin
						txState_r <= TX_TONE;
						txTone_r  <= reqTone;
					end
				end
				TX_TONE: begin
					if (!halfEnd) begin
						bitCnt_r <= bitCnt_r + 6'h1;
					end else begin
						bitCnt_r <= 6'h0;
						if (txDataEnable) begin
							// Balanced point reached; data follows.
							txState_r <= TX_DATA;
						end else if (txControlState == TCS_OFF || forceOff) begin
							txState_r <= TX_OFF;
						end else if (reqTone != TONE_NONE &&
								reqTone != txTone_r) begin
							// Same half kind continues in the new tone.
							txTone_r <= reqTone;
						end else begin
							// Same tone or reserved code: alternate halves.
							halfB_r <= ~halfB_r;
						end
					end
				end
				TX_DATA: begin
					bitCnt_r <= 6'h0;
					halfB_r  <= 1'b0;
					// Control state is ignored until the packet drains.
					if (!pipeBusy) begin
						if (reqTone != TONE_NONE && !forceOff) begin
							txState_r <= TX_TONE;
							txTone_r  <= reqTone;
						end else begin
							txState_r <= TX_OFF;
						end
					end
				end
				default: txState_r <= TX_OFF;
			endcase
		end
	end

	// Line drivers; the line is high for a one and low for a zero.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			txLine_r       <= 1'b0;
			txLineEnable_r <= 1'b0;
		end else begin
			// Data bits not yet valid at the tail are dropped preamble.
			txLine_r <= (txState_r == TX_DATA) ?
				pipeBit_r[TX_DEPTH-1] : toneBit;
			txLineEnable_r <= (txState_r != TX_OFF);
		end
	end

	// Run-length measurement on the received line.
	assign runDone  = (rxLine != rxPrev_r);
	assign doneTone = runTone(runLen_r);
	// Two agreeing tone runs are needed; a single error cannot fake two.
	assign confirmNow = runDone && doneTone != TONE_NONE &&
		doneTone == candTone_r && candCnt_r >= 2'(CONFIRM_RUNS - 1);
	assign preambleHit = runDone && runLen_r == 6'h1 &&
		altCnt_r >= 3'(PREAMBLE_RUNS - 1);

	// Run counters and tone candidate tracking.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rxPrev_r   <= 1'b0;
			runLen_r   <= 6'h1;
			lastRun_r  <= 6'h0;
			candTone_r <= TONE_NONE;
			candCnt_r  <= 2'h0;
			altCnt_r   <= 3'h0;
		end else begin
			rxPrev_r <= rxLine;
			if (!runDone) begin
				if (runLen_r != 6'h3f) begin
					runLen_r <= runLen_r + 6'h1;
				end
			end else begin
				runLen_r  <= 6'h1;
				lastRun_r <= runLen_r;
				if (doneTone == candTone_r) begin
					if (candCnt_r != 2'h3) begin
						candCnt_r <= candCnt_r + 2'h1;
					end
				end else begin
					candTone_r <= doneTone;
					candCnt_r  <= 2'h1;
				end
				if (runLen_r == 6'h1) begin
					if (altCnt_r != 3'h7) begin
						altCnt_r <= altCnt_r + 3'h1;
					end
				end else begin
					altCnt_r <= 3'h0;
				end
			end
		end
	end

	// Receive control state and data monitor.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rxCode_r <= RCS_MODE;
			inData_r <= 1'b0;
		end else if (!rxDataEnable) begin
			inData_r <= 1'b0;
			if (inData_r) begin
				// End of a received packet reports a mode transition.
				rxCode_r <= RCS_MODE;
			end else if (confirmNow) begin
				// Tone five leaves the reported state unchanged.
				case (doneTone)
					TONE_ONE:  rxCode_r <= RCS_ONE;
					TONE_TWO:  rxCode_r <= RCS_TWO;
					TONE_THR:  rxCode_r <= RCS_THREE;
					TONE_FOUR: rxCode_r <= RCS_FOUR;
					default:   rxCode_r <= rxCode_r;
				endcase
			end
		end else if (!inData_r) begin
			if (preambleHit) begin
				inData_r <= 1'b1;
				rxCode_r <= RCS_DATA;
			end
		end else if (confirmNow && rxCode_r == RCS_DATA) begin
			rxCode_r <= RCS_MODE;
		end
	end

	// Quarter-rate recovered clock, from preamble until enable falls.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			clkActive_r <= 1'b0;
			clkDiv_r    <= 2'h0;
			rx_recovered_clock_r     <= 1'b0;
		end else begin
			if (!rxDataEnable) begin
				clkActive_r <= 1'b0;
			end else if (preambleHit) begin
				clkActive_r <= 1'b1;
			end
			clkDiv_r <= clkActive_r ? clkDiv_r + 2'h1 : 2'h0;
			rx_recovered_clock_r  <= clkActive_r & clkDiv_r[1];
		end
	end

	assign prdata           = prdata_r;
	assign pready           = pready_r;
	assign pslverr          = pslverr_r;
	assign txLine           = txLine_r;
	assign txLineEnable     = txLineEnable_r;
	assign rxControlState   = rxCode_r;
	assign rxRecoveredClock = rx_recovered_clock_r;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_off_no_drive: assert property (
		txState_r == TX_OFF |=> !txLineEnable_r)
		else $error("Transmitter driven while off.");
	a_tone_starts_a: assert property (
		$past(txState_r) == TX_OFF && txState_r == TX_TONE |-> !halfB_r)
		else $error("Tone did not start with a first half.");
	a_leave_balanced: assert property (
		$past(txState_r) == TX_TONE && txState_r != TX_TONE
		|-> $past(halfEnd))
		else $error("Tone left before a half completed.");
	a_switch_keeps: assert property (
		halfEnd && !txDataEnable && !forceOff && reqTone != TONE_NONE &&
		reqTone != txTone_r |=> halfB_r == $past(halfB_r) &&
		txTone_r == $past(reqTone))
		else $error("Tone switch changed half kind.");
	a_data_to_a: assert property (
		$past(txState_r) == TX_DATA && txState_r == TX_TONE |-> !halfB_r)
		else $error("Tone after data began with a second half.");
	a_tone_one_run: assert property (
		txState_r == TX_TONE && txTone_r == TONE_ONE && !halfB_r &&
		bitCnt_r == 6'h0 ##1 1'b1 |-> txLine_r [*8] ##1 txLine_r [*8]
		##1 !txLine_r)
		else $error("Tone one first half is not sixteen ones.");
	a_data_latency: assert property (
		txState_r == TX_DATA && pipeVal_r[TX_DEPTH-1]
		|=> txLine_r == $past(laneBit, 10))
		else $error("Data latency differs from ten bit times.");
	a_rx_data_code: assert property (
		rxDataEnable && !inData_r && preambleHit
		|=> rxCode_r == RCS_DATA ##1 clkActive_r || !rxDataEnable)
		else $error("Preamble did not report data on link.");
	a_rx_nondata: assert property (
		rxDataEnable && inData_r && confirmNow && rxCode_r == RCS_DATA
		|=> rxCode_r == RCS_MODE)
		else $error("Tone during data not reported.");
	a_rx_tone_one: assert property (
		!rxDataEnable && !inData_r && confirmNow && doneTone == TONE_ONE
		|=> rxCode_r == RCS_ONE)
		else $error("Tone one not reported as 100.");
	a_clock_stops: assert property (
		!rxDataEnable |=> !clkActive_r ##1 !rx_recovered_clock_r)
		else $error("Recovered clock ran after enable fell.");

	c_tone_switch: cover property (halfEnd && reqTone != txTone_r &&
		reqTone != TONE_NONE && !txDataEnable);
	c_tone_to_data: cover property (txState_r == TX_TONE ##1
		txState_r == TX_DATA);
	c_data_to_tone: cover property (txState_r == TX_DATA ##1
		txState_r == TX_TONE);
	c_rx_preamble: cover property (rxDataEnable && preambleHit);
	c_rx_tone: cover property (confirmNow && !rxDataEnable);

endmodule

// file: logic/dsl_pkg.sv
// Shared constants, types and tone tables for the dual simplex link signaling.
package dsl_pkg;

	// Bit time is one sys_clk cycle; the line bit rate follows the clock.
	localparam int unsigned CLK_PERIOD_NS = 8;
	localparam int unsigned BIT_TIME_CLKS = 1;

	// Transmit data path depth, chosen to give 10 bit times lane-to-line.
	localparam int unsigned TX_PIPE_DEPTH = 9;
	localparam int unsigned TX_LAT_MIN_BT = 8;
	localparam int unsigned TX_LAT_MAX_BT = 12;

	// Receive decoding thresholds.
	localparam int unsigned CONFIRM_RUNS  = 2;
	localparam int unsigned PREAMBLE_RUNS = 6;
	localparam int unsigned RUN_W         = 6;

	// Transmit control state codes as seen on tx_control_state.
	localparam logic [2:0] TCS_OFF   = 3'h0;
	localparam logic [2:0] TCS_THREE = 3'h1;
	localparam logic [2:0] TCS_TWO   = 3'h2;
	localparam logic [2:0] TCS_FOUR  = 3'h3;
	localparam logic [2:0] TCS_ONE   = 3'h4;
	localparam logic [2:0] TCS_FIVE  = 3'h7;

	// Receive control state codes driven on rx_control_state.
	localparam logic [2:0] RCS_MODE  = 3'h0;
	localparam logic [2:0] RCS_THREE = 3'h1;
	localparam logic [2:0] RCS_TWO   = 3'h2;
	localparam logic [2:0] RCS_FOUR  = 3'h3;
	localparam logic [2:0] RCS_ONE   = 3'h4;
	localparam logic [2:0] RCS_DATA  = 3'h5;
	localparam logic [2:0] RCS_WARN  = 3'h7;

	// Tone index: 0..4 for tones one..five, NONE for no match.
	localparam logic [2:0] TONE_ONE  = 3'h0;
	localparam logic [2:0] TONE_TWO  = 3'h1;
	localparam logic [2:0] TONE_THR  = 3'h2;
	localparam logic [2:0] TONE_FOUR = 3'h3;
	localparam logic [2:0] TONE_FIVE = 3'h4;
	localparam logic [2:0] TONE_NONE = 3'h7;

	// Run length of each half pattern: first half, then second half.
	localparam logic [5:0] RUN_A [5] = '{6'h10, 6'h0e, 6'h0d, 6'h0b, 6'h0a};
	localparam logic [5:0] RUN_B [5] = '{6'h10, 6'h0f, 6'h0d, 6'h0c, 6'h0a};

	// Register map, byte addresses.
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_RUN    = 8'h08;
	localparam int unsigned CTRL_FORCE_OFF = 0;
	localparam logic [31:0] CTRL_RESET     = 32'h0;

	// Transmitter sequencing states.
	typedef enum logic [1:0] {TX_OFF, TX_TONE, TX_DATA} dsl_tx_e;

	// APB request from the master.
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dsl_apb_req_s;

endpackage

// file: tb/dsl_mii_partner.sv
// Behavioural model of the sublayer that drives the link's MII side.
`timescale 1ns/1ps

module dsl_mii_partner (
	input  wire logic       sys_clk,
	input  wire logic       reset,
	input  wire logic [2:0] reqState,
	input  wire logic       reqEnable,
	input  wire logic [3:0] reqLanes,
	input  wire logic       reqRxEnable,
	output logic [2:0]      txControlState,
	output logic            txDataEnable,
	output logic [3:0]      txLanes,
	output logic            rxDataEnable
);
	// Requests leave one edge after the bench asks, as from a registered
	// sublayer; the state is passed on even during data, because the
	// device has to ignore it then.
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			txControlState <= 3'h0;
			txDataEnable   <= 1'b0;
			txLanes        <= 4'h0;
			rxDataEnable   <= 1'b0;
		end else begin
			txControlState <= reqState;
			txDataEnable   <= reqEnable;
			txLanes        <= reqLanes;
			rxDataEnable   <= reqRxEnable;
		end
	end
endmodule

// file: tb/dsl_pmd_signaling_tb.sv
// Self-checking bench for the link signaling block.
`timescale 1ns/1ps

module dsl_pmd_signaling_tb;
	import dsl_pkg::*;

	logic         sys_clk;
	logic         reset;
	dsl_apb_req_s apbReq;
	logic [31:0]  prdata;
	logic         pready, pslverr, txLine, txLineEnable, rxLine;
	logic         rxDataEnable, rxRecoveredClock, txDataEnable;
	logic         reqEnable, reqRxEnable;
	logic [3:0]   txLanes, reqLanes;
	logic [2:0]   txControlState, rxControlState, reqState;
	int           miscompares, checks, bal;
	logic         capBits[$];
	int           runs[$];
	// Half-pattern run lengths of tones one to five, and their codes.
	int           tA[5] = '{16, 14, 13, 11, 10};
	int           tB[5] = '{16, 15, 13, 12, 10};
	logic [2:0]   tCode[5] = '{3'h4, 3'h2, 3'h1, 3'h3, 3'h7};

	dsl_pmd_signaling dut_u (
		.sys_clk(sys_clk), .reset(reset), .apbReq(apbReq),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.txLanes(txLanes), .txDataEnable(txDataEnable),
		.txControlState(txControlState), .txLine(txLine),
		.txLineEnable(txLineEnable), .rxLine(rxLine),
		.rxDataEnable(rxDataEnable), .rxControlState(rxControlState),
		.rxRecoveredClock(rxRecoveredClock)
	);

	dsl_mii_partner mii_u (
		.sys_clk(sys_clk), .reset(reset), .reqState(reqState),
		.reqEnable(reqEnable), .reqLanes(reqLanes),
		.reqRxEnable(reqRxEnable), .txControlState(txControlState),
		.txDataEnable(txDataEnable), .txLanes(txLanes),
		.rxDataEnable(rxDataEnable)
	);

	// Free-running 125 MHz clock.
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Expected line bit at position p of a tone: ones-leading half first.
	function automatic logic tone_bit(int p, int a, int b);
		int q;
		q = p % (2 * a + 2 * b);
		return (q < a) || (q >= 2 * a + b);
	endfunction

	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Single place where the run ends.
	task automatic print_verdict();
		$display("Comparisons %0d, miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// A wait that ran out of its bound is a failure of its own.
	task automatic time_out();
		miscompares++;
		print_verdict();
	endtask

	// One APB transfer; entered just after a rising edge.
	task automatic apb(input logic wr, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd, output logic err);
		int n;
		apbReq <= '{1'b1, 1'b0, wr, a, wd};
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		apbReq <= '{1'b0, 1'b0, wr, a, wd};
		// Let the release reach an edge before any next request.
		@(posedge sys_clk);
		if (n >= 16) time_out();
	endtask

	// Records every line bit from enable rising to enable falling.
	task automatic capture();
		int n;
		capBits.delete();
		n = 0;
		while (txLineEnable !== 1'b1 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 40) time_out();
		while (txLineEnable === 1'b1 && n < 700) begin
			capBits.push_back(txLine);
			@(posedge sys_clk);
			n++;
		end
		if (n >= 700) time_out();
	endtask

	// Ones minus zeros of the capture, and its runs of equal bits.
	task automatic analyse();
		int len;
		bal = 0;
		len = 0;
		runs.delete();
		foreach (capBits[i]) begin
			bal += capBits[i] ? 1 : -1;
			if (i > 0 && capBits[i] !== capBits[i - 1]) begin
				runs.push_back(len);
				len = 0;
			end
			len++;
		end
		runs.push_back(len);
	endtask

	// Sends whole tone periods on the receive line, bit flip inverted unless flip is -1.
	task automatic rx_tone(input int a, input int b, input int reps,
			input int flip);
		for (int i = 0; i < reps * 2 * (a + b); i++) begin
			rxLine <= tone_bit(i, a, b) ^ (i == flip);
			@(posedge sys_clk);
		end
	endtask

	initial begin
		logic [31:0] rd;
		logic        err;
		int          n;
		int          rises;
		logic        prevClk;
		miscompares = 0;
		checks = 0;
		reset = 1'b1;
		apbReq = '0;
		rxLine = 1'b0;
		reqState = 3'h0;
		reqEnable = 1'b0;
		reqLanes = 4'h0;
		reqRxEnable = 1'b0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		chk(32'(txLineEnable), 32'h0);
		chk(32'(rxControlState), 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		chk(rd, CTRL_RESET);
		// Every tone from off: full period, then balanced switch-off.
		for (int t = 0; t < 5; t++) begin
			fork
				capture();
				begin
					reqState <= tCode[t];
					repeat (2 * (tA[t] + tB[t]) + 4) @(posedge sys_clk);
					reqState <= 3'h0;
				end
			join
			analyse();
			for (int i = 0; i < 2 * (tA[t] + tB[t]); i++) begin
				chk(32'(capBits[i]), 32'(tone_bit(i, tA[t], tB[t])));
			end
			chk(32'(bal), 32'h0);
			repeat (4) @(posedge sys_clk);
		end
		// Tone three changed to tone five part-way through a first half.
		fork
			capture();
			begin
				reqState <= 3'h1;
				repeat (8) @(posedge sys_clk);
				reqState <= 3'h7;
				repeat (60) @(posedge sys_clk);
				reqState <= 3'h0;
			end
		join
		analyse();
		chk(32'(runs[0]), 32'd13);
		chk(32'(runs[1]), 32'd13);
		chk(32'(runs[2]), 32'd10);
		chk(32'(runs[3]), 32'd20);
		chk(32'(bal), 32'h0);
		// Packet data after tone one, with latency and tail checks.
		reqState <= 3'h4;
		repeat (20) @(posedge sys_clk);
		reqEnable <= 1'b1;
		repeat (70) @(posedge sys_clk);
		chk(32'(txLine), 32'h0);
		reqLanes <= 4'hf;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (txLine !== 1'b1 && n < 30);
		chk(32'(n), 32'(TX_PIPE_DEPTH + 3));
		reqState <= 3'h0;
		repeat (10) @(posedge sys_clk);
		chk(32'(txLineEnable), 32'h1);
		chk(32'(txLine), 32'h1);
		reqState <= 3'h4;
		reqLanes <= 4'h0;
		repeat (16) @(posedge sys_clk);
		reqEnable <= 1'b0;
		n = 0;
		while (txLine !== 1'b1 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		n = 0;
		while (txLine === 1'b1 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(n), 32'd16);
		reqState <= 3'h0;
		repeat (80) @(posedge sys_clk);
		// Forced off through the register, then an unmapped access.
		reqState <= 3'h7;
		repeat (10) @(posedge sys_clk);
		apb(1'b1, ADDR_CTRL, 32'h1, rd, err);
		repeat (40) @(posedge sys_clk);
		chk(32'(txLineEnable), 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
		chk(rd, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
		chk({29'h0, rd[3:1]}, 32'h0);
		apb(1'b0, 8'h0c, 32'h0, rd, err);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h0, rd, err);
		reqState <= 3'h0;
		// Receive decoding of tones one to four, then tone five.
		for (int t = 0; t < 4; t++) begin
			rx_tone(tA[t], tB[t], 3, -1);
			chk(32'(rxControlState), 32'(tCode[t]));
		end
		rx_tone(tA[4], tB[4], 3, -1);
		chk(32'(rxControlState), 32'h3);
		rx_tone(tA[1], tB[1], 3, -1);
		rx_tone(tA[1], tB[1], 3, 20);
		chk(32'(rxControlState), 32'h2);
		// Preamble, recovered clock, then a tone inside the packet.
		reqRxEnable <= 1'b1;
		for (int i = 0; i < 48; i++) begin
			rxLine <= i[0];
			@(posedge sys_clk);
		end
		chk(32'(rxControlState), 32'(RCS_DATA));
		rises = 0;
		prevClk = rxRecoveredClock;
		for (int i = 0; i < 16; i++) begin
			rxLine <= i[0];
			@(posedge sys_clk);
			if (rxRecoveredClock === 1'b1 && prevClk === 1'b0) rises++;
			prevClk = rxRecoveredClock;
		end
		chk(32'(rises), 32'd4);
		// Two periods, so three whole inner runs are seen and the tone is confirmed.
		rx_tone(tA[4], tB[4], 2, -1);
		chk(32'(rxControlState), 32'(RCS_MODE));
		reqRxEnable <= 1'b0;
		rx_tone(tA[0], tB[0], 2, -1);
		chk(32'(rxRecoveredClock), 32'h0);
		chk(32'(rxControlState), 32'h4);
		print_verdict();
	end
endmodule
